//--- common/sfa_pkg.sv
// Constants and types shared by the frame timing and attribute block
`default_nettype none
package sfa_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int             ADDR_W        = 8;
	localparam int             NUM_ATTR      = 6;
	localparam logic [7:0]     ADR_CONFIG    = 8'h00;
	localparam logic [7:0]     ADR_TALLY     = 8'h08;
	localparam logic [7:0]     ADR_ATTR_FIRST = 8'h0c;
	localparam logic [7:0]     ADR_ATTR_LAST = 8'h20;
	localparam logic [7:0]     ADR_STATUS    = 8'h2c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CFG_MASTER_SELECT_BIT  = 31;
	localparam int CFG_HALT_BIT           = 0;
	localparam int STAT_RUNNING_BIT       = 30;
	localparam int STAT_BUSY_BIT          = 0;
	localparam int TALLY_LSB              = 16;
	localparam int DOUBLE_RATE_BIT        = 31;
	localparam int FRAME_BITS_CODE_HI     = 30;
	localparam int FRAME_BITS_CODE_LO     = 27;
	localparam int CLOCK_IDLE_LEVEL_BIT   = 26;
	localparam int CLOCK_EDGE_PHASE_BIT   = 25;
	localparam int LOW_BIT_FIRST_BIT      = 24;
	localparam int SEL_TO_CLK_PRESCALE_LO = 22;
	localparam int AFTER_CLK_PRESCALE_LO  = 20;
	localparam int POST_FRAME_PRESCALE_LO = 18;
	localparam int RATE_PRESCALE_LO       = 16;
	localparam int SEL_TO_CLK_SCALE_LO    = 12;
	localparam int AFTER_CLK_SCALE_LO     = 8;
	localparam int POST_FRAME_SCALE_LO    = 4;
	localparam int RATE_SCALE_LO          = 0;

	// ****************************************
	// Reset values and widths
	// ****************************************
	localparam logic        CFG_HALT_RST      = 1'b1;
	localparam logic        CFG_MASTER_RST    = 1'b0;
	localparam logic [31:0] ATTR_RST          = 32'h7800_0000;
	localparam logic [3:0]  FRAME_CODE_MIN    = 4'h3;
	localparam int          CNT_W             = 20;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_LEAD_IN = 6'h02,
		ST_SHIFT   = 6'h04,
		ST_TAIL    = 6'h08,
		ST_GAP     = 6'h10,
		ST_SLAVE   = 6'h20
	} sfa_state_t;
endpackage
`default_nettype wire

//--- rtl/sfa_core.sv
// Frame tally, attribute registers and frame timing engine of the serial controller
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sfa_core (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic [2:0]  cmd_attr_set_select_i,
	input  wire logic        cmd_tally_clear_flag_i,
	input  wire logic [15:0] cmd_data_i,
	output logic             rx_valid_o,
	output logic      [15:0] rx_data_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	input  wire logic        cs_n_i,
	output logic             chip_select_line_n_o,
	input  wire logic        sin_i,
	output logic             sout_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		sfa_pkg::sfa_state_t      st;
		logic                     halt;
		logic                     master_select;
		logic [5:0][31:0]         attr;
		logic [31:0]              act;
		logic [15:0]              frame_tally;
		logic [19:0]              cnt;
		logic                     half;
		logic [4:0]               idx;
		logic [15:0]              tx;
		logic [15:0]              rx;
		logic                     sck;
		logic                     sck_oe;
		logic                     cs_n;
		logic                     sout;
		logic                     cmd_ready;
		logic                     rx_valid;
		logic [15:0]              rx_data;
		logic [31:0]              rdata;
		logic [2:0]               sck_sy;
		logic [2:0]               cs_sy;
		logic [1:0]               sin_sy;
	} sfa_st_t;

	sfa_st_t     q;
	sfa_st_t     d;
	logic        lead;
	logic        trail;
	logic        start;
	logic        done;
	logic [4:0]  nb;
	logic        lsb;
	logic        last;
	logic        clock_edge_phase;
	logic        tally_wr;
	logic        take_cmd;
	logic [31:0] sel_attr;

	// ****************************************
	// Decoding and arithmetic
	// ****************************************
	function automatic logic [19:0] f_odd_pre(input logic [1:0] c);
		case (c)
			2'h0:    f_odd_pre = 20'h1;
			2'h1:    f_odd_pre = 20'h3;
			2'h2:    f_odd_pre = 20'h5;
			default: f_odd_pre = 20'h7;
		endcase
	endfunction

	function automatic logic [19:0] f_rate_pre(input logic [1:0] c);
		case (c)
			2'h0:    f_rate_pre = 20'h2;
			2'h1:    f_rate_pre = 20'h3;
			2'h2:    f_rate_pre = 20'h5;
			default: f_rate_pre = 20'h7;
		endcase
	endfunction

	function automatic logic [19:0] f_rate_scale(input logic [3:0] c);
		case (c)
			4'h0:    f_rate_scale = 20'h2;
			4'h1:    f_rate_scale = 20'h4;
			4'h2:    f_rate_scale = 20'h6;
			4'h3:    f_rate_scale = 20'h8;
			default: f_rate_scale = 20'h1 << c;
		endcase
	endfunction

	// Prescale times power-of-two scale; largest is 7 * 65536, inside 20 bits
	function automatic logic [19:0] f_delay(input logic [1:0] pre, input logic [3:0] scl);
		logic [19:0] pw;
		pw      = 20'h2 << scl;
		f_delay = f_odd_pre(pre) * pw;
	endfunction

	// Clock period in bus cycles; the double rate halves it
	function automatic logic [19:0] f_period(input logic [31:0] a);
		logic [19:0] p;
		p = f_rate_pre(a[sfa_pkg::RATE_PRESCALE_LO +: 2])
			* f_rate_scale(a[sfa_pkg::RATE_SCALE_LO +: 4]);
		f_period = a[sfa_pkg::DOUBLE_RATE_BIT] ? (p >> 1) : p;
	endfunction

	// Cycles from leading to trailing edge; odd periods give the uneven duty
	function automatic logic [19:0] f_h0(input logic [31:0] a);
		logic [19:0] p;
		p    = f_period(a);
		f_h0 = a[sfa_pkg::CLOCK_EDGE_PHASE_BIT] ? (p - (p >> 1)) : (p >> 1);
	endfunction

	// Reserved size codes behave as the smallest frame
	function automatic logic [4:0] f_nbits(input logic [31:0] a);
		logic [3:0] c;
		c       = a[sfa_pkg::FRAME_BITS_CODE_LO +: 4];
		f_nbits = (c < sfa_pkg::FRAME_CODE_MIN) ? 5'h4 : ({1'b0, c} + 5'h1);
	endfunction

	function automatic logic [3:0] f_pos(input logic [4:0] i, input logic [4:0] n,
		input logic l);
		logic [4:0] m;
		m     = n - 5'h1 - i;
		f_pos = l ? i[3:0] : m[3:0];
	endfunction

	function automatic logic f_attr_hit(input logic [7:0] a);
		f_attr_hit = (a >= sfa_pkg::ADR_ATTR_FIRST) && (a <= sfa_pkg::ADR_ATTR_LAST)
			&& (a[1:0] == 2'h0);
	endfunction

	function automatic logic [2:0] f_attr_idx(input logic [7:0] a);
		logic [7:0] o;
		o          = (a - sfa_pkg::ADR_ATTR_FIRST) >> 2;
		f_attr_idx = o[2:0];
	endfunction

	// Selects 6 and 7 have no set behind them and fall back to set zero
	function automatic logic [2:0] f_sel(input logic [2:0] s);
		f_sel = (s >= 3'h6) ? 3'h0 : s;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		d        = q;
		lead     = 1'b0;
		trail    = 1'b0;
		start    = 1'b0;
		done     = 1'b0;
		nb       = f_nbits(q.act);
		lsb      = q.master_select & q.act[sfa_pkg::LOW_BIT_FIRST_BIT];
		last     = (q.idx == (nb - 5'h1));
		clock_edge_phase     = q.act[sfa_pkg::CLOCK_EDGE_PHASE_BIT];
		tally_wr = wr_i && (addr_i == sfa_pkg::ADR_TALLY);
		take_cmd = cmd_valid_i && q.cmd_ready;
		sel_attr = q.attr[f_sel(cmd_attr_set_select_i)];
		d.sck_sy = {q.sck_sy[1:0], sck_i};
		d.cs_sy  = {q.cs_sy[1:0], cs_n_i};
		d.sin_sy = {q.sin_sy[0], sin_i};
		d.rx_valid = 1'b0;

		// Register writes
		if (wr_i)
		begin
			if (addr_i == sfa_pkg::ADR_CONFIG)
			begin
				d.master_select = wdata_i[sfa_pkg::CFG_MASTER_SELECT_BIT];
				d.halt          = wdata_i[sfa_pkg::CFG_HALT_BIT];
			end
			if (tally_wr)
				d.frame_tally = wdata_i[sfa_pkg::TALLY_LSB +: 16];
			if (f_attr_hit(addr_i))
				d.attr[f_attr_idx(addr_i)] = wdata_i;
		end

		// Register reads, answered in the next cycle
		if (rd_i)
		begin
			d.rdata = 32'h0;
			if (addr_i == sfa_pkg::ADR_CONFIG)
			begin
				d.rdata[sfa_pkg::CFG_MASTER_SELECT_BIT] = q.master_select;
				d.rdata[sfa_pkg::CFG_HALT_BIT]          = q.halt;
			end
			if (addr_i == sfa_pkg::ADR_TALLY)
				d.rdata[sfa_pkg::TALLY_LSB +: 16] = q.frame_tally;
			if (addr_i == sfa_pkg::ADR_STATUS)
			begin
				d.rdata[sfa_pkg::STAT_RUNNING_BIT] = ~q.halt;
				d.rdata[sfa_pkg::STAT_BUSY_BIT]    = (q.st != sfa_pkg::ST_IDLE);
			end
			if (f_attr_hit(addr_i))
				d.rdata = q.attr[f_attr_idx(addr_i)];
		end

		// Sequencer
		case (q.st)
			sfa_pkg::ST_IDLE:
			begin
				d.cs_n   = 1'b1;
				d.half   = 1'b0;
				d.sck_oe = q.master_select;
				if (q.master_select)
					d.sck = q.attr[0][sfa_pkg::CLOCK_IDLE_LEVEL_BIT];
				if (!q.halt && q.master_select && take_cmd)
				begin
					start = 1'b1;
					d.act = sel_attr;
					d.st  = sfa_pkg::ST_LEAD_IN;
					d.cs_n = 1'b0;
					d.sck = sel_attr[sfa_pkg::CLOCK_IDLE_LEVEL_BIT];
					d.cnt = f_delay(sel_attr[sfa_pkg::SEL_TO_CLK_PRESCALE_LO +: 2],
						sel_attr[sfa_pkg::SEL_TO_CLK_SCALE_LO +: 4]);
				end
				else if (!q.halt && !q.master_select && !q.cs_sy[1] && q.cs_sy[2])
				begin
					start = 1'b1;
					d.act = q.attr[0];
					d.st  = sfa_pkg::ST_SLAVE;
				end
				if (start)
				begin
					d.tx  = take_cmd ? cmd_data_i : 16'h0;
					d.idx = 5'h0;
					d.rx  = 16'h0;
					if (take_cmd && cmd_tally_clear_flag_i)
						d.frame_tally = 16'h0;
					// Phase zero puts the first bit out before any edge
					if (!d.act[sfa_pkg::CLOCK_EDGE_PHASE_BIT])
						d.sout = d.tx[f_pos(5'h0, f_nbits(d.act),
							q.master_select & d.act[sfa_pkg::LOW_BIT_FIRST_BIT])];
				end
			end
			sfa_pkg::ST_LEAD_IN:
			begin
				d.cnt = q.cnt - 20'h1;
				if (q.cnt == 20'h1)
				begin
					lead = 1'b1;
					d.st = sfa_pkg::ST_SHIFT;
				end
			end
			sfa_pkg::ST_SHIFT:
			begin
				d.cnt = q.cnt - 20'h1;
				if (q.cnt == 20'h1)
				begin
					lead  = q.half;
					trail = ~q.half;
				end
			end
			sfa_pkg::ST_TAIL:
			begin
				d.cnt = q.cnt - 20'h1;
				if (q.cnt == 20'h1)
				begin
					d.cs_n = 1'b1;
					d.st   = sfa_pkg::ST_GAP;
					d.cnt  = f_delay(q.act[sfa_pkg::POST_FRAME_PRESCALE_LO +: 2],
						q.act[sfa_pkg::POST_FRAME_SCALE_LO +: 4]);
				end
			end
			sfa_pkg::ST_GAP:
			begin
				d.cnt = q.cnt - 20'h1;
				if (q.cnt == 20'h1)
					d.st = sfa_pkg::ST_IDLE;
			end
			sfa_pkg::ST_SLAVE:
			begin
				// Edges come from the external clock after synchronising
				if (q.cs_sy[1])
					d.st = sfa_pkg::ST_IDLE;
				else if (q.sck_sy[1] != q.sck_sy[2])
				begin
					lead  = (q.sck_sy[1] != q.act[sfa_pkg::CLOCK_IDLE_LEVEL_BIT]);
					trail = (q.sck_sy[1] == q.act[sfa_pkg::CLOCK_IDLE_LEVEL_BIT]);
				end
			end
			default:
				d.st = sfa_pkg::ST_IDLE;
		endcase

		// Edge actions shared by master and slave
		if (lead)
		begin
			if (q.master_select)
			begin
				d.sck  = ~q.sck;
				d.half = 1'b0;
				d.cnt  = f_h0(q.act);
			end
			if (!clock_edge_phase)
				d.rx[f_pos(q.idx, nb, lsb)] = q.sin_sy[1];
			else
				d.sout = q.tx[f_pos(q.idx, nb, lsb)];
		end
		if (trail)
		begin
			if (q.master_select)
			begin
				d.sck  = ~q.sck;
				d.half = 1'b1;
				d.cnt  = f_period(q.act) - f_h0(q.act);
			end
			if (clock_edge_phase)
				d.rx[f_pos(q.idx, nb, lsb)] = q.sin_sy[1];
			d.idx = q.idx + 5'h1;
			if (last)
			begin
				done = 1'b1;
				d.frame_tally = d.frame_tally + 16'h1;
				d.rx_valid    = 1'b1;
				d.rx_data     = d.rx;
				if (q.master_select)
				begin
					d.st  = sfa_pkg::ST_TAIL;
					d.cnt = f_delay(q.act[sfa_pkg::AFTER_CLK_PRESCALE_LO +: 2],
						q.act[sfa_pkg::AFTER_CLK_SCALE_LO +: 4]);
				end
				else
					d.st = sfa_pkg::ST_IDLE;
			end
			else if (!clock_edge_phase)
				d.sout = q.tx[f_pos(q.idx + 5'h1, nb, lsb)];
		end

		d.cmd_ready = (d.st == sfa_pkg::ST_IDLE) && !d.halt;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			q               <= '0;
			q.st            <= sfa_pkg::ST_IDLE;
			q.halt          <= sfa_pkg::CFG_HALT_RST;
			q.master_select <= sfa_pkg::CFG_MASTER_RST;
			q.attr          <= {sfa_pkg::NUM_ATTR{sfa_pkg::ATTR_RST}};
			q.cs_n          <= 1'b1;
			q.cs_sy         <= 3'h7;
		end
		else
			q <= d;
	end

	assign rdata_o              = q.rdata;
	assign cmd_ready_o          = q.cmd_ready;
	assign rx_valid_o           = q.rx_valid;
	assign rx_data_o            = q.rx_data;
	assign sck_o                = q.sck;
	assign sck_oe_o             = q.sck_oe;
	assign chip_select_line_n_o = q.cs_n;
	assign sout_o               = q.sout;

	// ****************************************
	// Checks
	// ****************************************
	logic [19:0] stay_h;
	logic [4:0]  trail_h;

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			stay_h  <= 20'h0;
			trail_h <= 5'h0;
		end
		else
		begin
			stay_h  <= ((d.st != q.st) || (d.sck != q.sck)) ? 20'h1 : (stay_h + 20'h1);
			trail_h <= start ? 5'h0 : (trail ? (trail_h + 5'h1) : trail_h);
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	chk_tally_step: assert property (done && !tally_wr |=>
		q.frame_tally == $past(q.frame_tally) + 16'h1)
		else $error("tally did not step by one");
	chk_tally_preset: assert property (tally_wr && !done && !(take_cmd && start && cmd_tally_clear_flag_i) |=>
		q.frame_tally == $past(wdata_i[31:16]))
		else $error("tally preset lost");
	chk_tally_zero: assert property (start && take_cmd && cmd_tally_clear_flag_i && !tally_wr
		|=> q.frame_tally == 16'h0)
		else $error("tally not cleared at frame start");
	chk_attr_pick: assert property (start && q.master_select |=>
		q.act == $past(sel_attr))
		else $error("wrong attribute set in master frame");
	chk_slave_attr: assert property (start && !q.master_select |=>
		q.act == $past(q.attr[0]) && q.st == sfa_pkg::ST_SLAVE)
		else $error("slave frame not on set zero");
	chk_lead_delay: assert property (q.st == sfa_pkg::ST_LEAD_IN && lead |->
		stay_h == f_delay(q.act[23:22], q.act[15:12]))
		else $error("select to clock delay wrong");
	chk_after_delay: assert property (q.st == sfa_pkg::ST_TAIL && q.cnt == 20'h1 |->
		stay_h == f_delay(q.act[21:20], q.act[11:8]) ##1 q.cs_n)
		else $error("after clock delay wrong");
	chk_gap_delay: assert property (q.st == sfa_pkg::ST_GAP && q.cnt == 20'h1 |->
		stay_h == f_delay(q.act[19:18], q.act[7:4]) && q.cs_n)
		else $error("post frame gap wrong");
	chk_clock_duty: assert property (q.st == sfa_pkg::ST_SHIFT && trail |->
		stay_h == f_h0(q.act) ##1 q.sck != $past(q.sck))
		else $error("clock half period wrong");
	chk_frame_bits: assert property (done |-> trail_h + 5'h1 == nb)
		else $error("frame bit count wrong");
	chk_idle_level: assert property (q.st == sfa_pkg::ST_LEAD_IN |->
		q.sck == q.act[sfa_pkg::CLOCK_IDLE_LEVEL_BIT] && !q.cs_n)
		else $error("clock not at idle level before first edge");
endmodule // sfa_core
`default_nettype wire

//--- verif/sfa_spi_peer.sv
// Behavioural serial peripheral facing the frame engine in master mode
`timescale 1ns/10ps
`default_nettype none
module sfa_spi_peer (
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic        clock_idle_level_i,
	input  wire logic        clock_edge_phase_i,
	input  wire logic        lsb_i,
	input  wire logic [4:0]  nbits_i,
	input  wire logic [15:0] tx_i,
	output logic             miso_o,
	output logic      [15:0] cap_o,
	output logic      [4:0]  nsamp_o
);
	function automatic int pos(input int i);
		return lsb_i ? i : int'(nbits_i) - 1 - i;
	endfunction

	int nedge = 0;

	initial miso_o = 1'b0;

	always @(negedge cs_n_i)
	begin
		nedge = 0;
		nsamp_o = '0;
		cap_o = '0;
		miso_o = clock_edge_phase_i ? ~miso_o : tx_i[pos(0)];
	end

	// Released line flips so a stale bit never passes for data
	always @(posedge cs_n_i)
		miso_o = ~miso_o;

	always @(sck_i)
	begin
		// A move onto the idle level before any edge is the idle level settling, not a clock edge
		if (cs_n_i === 1'b0 && !(nedge == 0 && sck_i == clock_idle_level_i))
		begin
			nedge++;
			if ((sck_i != clock_idle_level_i) ^ clock_edge_phase_i)
			begin
				if (nsamp_o < nbits_i)
					cap_o[pos(int'(nsamp_o))] = mosi_i;
				nsamp_o = nsamp_o + 5'h01;
			end
			else
				miso_o = (nsamp_o < nbits_i) ? tx_i[pos(int'(nsamp_o))] : ~miso_o;
		end
	end
endmodule // sfa_spi_peer
`default_nettype wire

//--- verif/tb_spi_frame_timing_attributes.sv
// Self-checking bench for the frame tally, attribute sets and frame timing
`timescale 1ns/10ps
`default_nettype none
module tb_spi_frame_timing_attributes;
	logic        sys_clk_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic [7:0]  addr      = '0;
	logic [31:0] wdata     = '0;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic [31:0] rdata;
	logic        cmd_valid = 1'b0;
	logic        cmd_ready;
	logic [2:0]  cmd_sel   = '0;
	logic        cmd_clr   = 1'b0;
	logic [15:0] cmd_data  = '0;
	logic        rx_valid;
	logic [15:0] rx_data;
	logic        sck;
	logic        sck_oe;
	logic        cs_n;
	logic        sout;
	logic        miso;
	logic        p_clock_idle_level    = 1'b0;
	logic        p_clock_edge_phase    = 1'b0;
	logic        p_lsb     = 1'b0;
	logic [4:0]  p_nb      = 5'h04;
	logic [15:0] p_tx      = '0;
	logic [15:0] cap;
	logic [4:0]  nsamp;
	logic [15:0] cur_data  = '0;
	logic        cs_q      = 1'b1;
	logic        sck_q     = 1'b0;
	logic [31:0] seed      = 32'h00005fbe;
	logic        s_mode    = 1'b0;
	logic        s_sck     = 1'b0;
	logic        s_cs_n    = 1'b1;
	logic        s_din     = 1'b0;
	logic [31:0] r_s;
	logic [31:0] attr [6]  = '{32'h38400001, 32'h7f251010, 32'h98df0000,
		32'h9f020200, 32'h5c822002, 32'h4b080023};
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          tally     = 0;
	int          cyc       = 0;
	int          had_rise  = 0;
	int          nb, n_dly, a_dly, g_dly, per, h0, g_prev, t_fall, t_prev, t_rise, ntog, k;

	always #10 sys_clk_i = ~sys_clk_i;

	sfa_core uut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_attr_set_select_i(cmd_sel),
		.cmd_tally_clear_flag_i(cmd_clr), .cmd_data_i(cmd_data), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .sck_i(s_sck), .sck_o(sck), .sck_oe_o(sck_oe), .cs_n_i(s_cs_n),
		.chip_select_line_n_o(cs_n), .sin_i(s_mode ? s_din : miso), .sout_o(sout)
	);

	sfa_spi_peer peer (
		.sck_i(sck), .cs_n_i(cs_n), .mosi_i(sout), .clock_idle_level_i(p_clock_idle_level), .clock_edge_phase_i(p_clock_edge_phase),
		.lsb_i(p_lsb), .nbits_i(p_nb), .tx_i(p_tx), .miso_o(miso), .cap_o(cap),
		.nsamp_o(nsamp)
	);

	// ****************************************
	// Reference model
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int dly(input logic [1:0] p, input logic [3:0] s);
		return (2 * int'(p) + 1) * (2 << s);
	endfunction

	function automatic logic [15:0] msk();
		return 16'((32'h1 << nb) - 1);
	endfunction

	task automatic cfg_load(input int i);
		logic [31:0] w;
		int          rp [4];
		int          sc;
		w = attr[i];
		rp = '{2, 3, 5, 7};
		sc = int'(w[3:0]);
		nb = (w[30:27] < 4'h3) ? 4 : int'(w[30:27]) + 1;
		per = (rp[w[17:16]] * ((sc < 4) ? 2 * sc + 2 : 1 << sc)) >> w[31];
		h0 = w[25] ? per - per / 2 : per / 2;
		n_dly = dly(w[23:22], w[15:12]);
		a_dly = dly(w[21:20], w[11:8]);
		g_dly = dly(w[19:18], w[7:4]);
		p_clock_idle_level = w[26];
		p_clock_edge_phase = w[25];
		p_lsb = w[24];
		p_nb = 5'(nb);
	endtask

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		@(posedge sys_clk_i);
		chk(rdata, exp);
	endtask

	task automatic wait_idle();
		int i;
		// Ready still shows its pre-accept value in the accepting time step
		@(posedge sys_clk_i);
		for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++)
			@(posedge sys_clk_i);
		if (i >= 4000)
			chk(32'h0, 32'h1);
		repeat (2) @(posedge sys_clk_i);
	endtask

	// Next frame's data is offered while the current one still runs
	task automatic send(input logic [2:0] sel, input logic clr);
		logic [31:0] r;
		int          i;
		r = xs();
		@(posedge sys_clk_i);
		cmd_valid <= 1'b1;
		cmd_sel <= sel;
		cmd_clr <= clr;
		cmd_data <= r[15:0];
		i = 0;
		do
		begin
			@(posedge sys_clk_i);
			i++;
		end
		while (cmd_ready !== 1'b1 && i < 4000);
		cmd_valid <= 1'b0;
		if (i >= 4000)
			chk(32'h0, 32'h1);
		cfg_load(sel > 3'h5 ? 0 : int'(sel));
		cur_data = r[15:0];
		r = xs();
		p_tx = r[15:0];
		if (clr)
			tally = 0;
	endtask

	// ****************************************
	// Wire monitor
	// ****************************************
	always @(posedge sys_clk_i)
	begin
		cyc = cyc + 1;
		if (nrst_i)
		begin
			if (cs_q && !cs_n)
			begin
				if (had_rise != 0)
					chk({31'h0, (cyc - t_rise) >= g_prev}, 32'h1);
				chk({31'h0, sck}, {31'h0, p_clock_idle_level});
				t_fall = cyc;
				ntog = 0;
				// Idle level of the new set lands together with the select
				sck_q = sck;
			end
			if (!cs_n && sck != sck_q)
			begin
				if (ntog == 0)
					chk(32'(cyc - t_fall), 32'(n_dly));
				if (ntog == 1)
					chk(32'(cyc - t_prev), 32'(h0));
				if (ntog == 2)
					chk(32'(cyc - t_prev), 32'(per - h0));
				t_prev = cyc;
				ntog++;
			end
			if (!cs_q && cs_n)
			begin
				chk(32'(ntog), 32'(2 * nb));
				chk(32'(cyc - t_prev), 32'(a_dly));
				chk({16'h0, cap}, {16'h0, cur_data & msk()});
				t_rise = cyc;
				had_rise = 1;
				g_prev = g_dly;
			end
			if (rx_valid)
			begin
				chk({16'h0, rx_data}, {16'h0, p_tx & msk()});
				tally = (tally + 1) % 65536;
			end
			cs_q = cs_n;
			sck_q = sck;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		chk({30'h0, cs_n, sck_oe}, 32'h2);
		rd_chk(8'h0c, 32'h78000000);
		rd_chk(8'h08, 32'h0);
		wr_reg(8'h04, 32'hffffffff);
		rd_chk(8'h04, 32'h0);
		for (k = 0; k < 6; k++)
			wr_reg(8'h0c + 8'(4 * k), attr[k]);
		rd_chk(8'h1c, attr[4]);
		rd_chk(8'h10, attr[1]);
		wr_reg(8'h08, 32'hffff0000);
		rd_chk(8'h08, 32'hffff0000);
		tally = 65535;
		wr_reg(8'h00, 32'h80000000);
		rd_chk(8'h2c, 32'h40000000);
		chk({31'h0, sck_oe}, 32'h1);
		send(3'h0, 1'b0);
		wait_idle();
		rd_chk(8'h08, 32'(tally) << 16);
		for (k = 1; k < 8; k++)
			send(3'(k), k == 3);
		wait_idle();
		rd_chk(8'h08, 32'(tally) << 16);
		// Slave frame clocked by the bench on set zero, most significant bit first
		wr_reg(8'h00, 32'h0);
		cfg_load(0);
		r_s = xs();
		p_tx = r_s[15:0];
		s_mode <= 1'b1;
		s_cs_n <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		chk({31'h0, sck_oe}, 32'h0);
		for (k = 7; k >= 0; k--)
		begin
			s_din <= p_tx[k];
			repeat (4) @(posedge sys_clk_i);
			s_sck <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			s_sck <= 1'b0;
		end
		repeat (6) @(posedge sys_clk_i);
		s_cs_n <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		rd_chk(8'h08, 32'(tally) << 16);
		results();
	end

	// Frames here need at most a few hundred cycles each; the limit leaves ample margin
	initial
	begin
		#400000;
		error_cnt++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		results();
	end
endmodule // tb_spi_frame_timing_attributes
`default_nettype wire
